// ===== verilog/power_clk_pkg.sv
package power_clk_pkg;

   // Register indices on the plain register port
   localparam logic [1:0] ADDR_CLK_MODE  = 2'h0;
   localparam logic [1:0] ADDR_CLK_MODE2 = 2'h1;
   localparam logic [1:0] ADDR_STATUS    = 2'h2;

   // Primary clock mode register layout
   localparam int BIT_HS_SELECT    = 0;
   localparam int BIT_IDLE_SELECT  = 1;
   localparam int BIT_HS_READY     = 2;
   localparam int BIT_LS_READY     = 3;
   localparam int BIT_FAST_WAKE_EN = 4;
   localparam int DIV_SEL_LSB      = 5;
   localparam int DIV_SEL_MSB      = 7;

   // Secondary clock mode register layout
   localparam int RST_FLAGS_LSB      = 0;
   localparam int RST_FLAGS_MSB      = 3;
   localparam int BIT_IDLE_SYSCLK_ON = 7;

   // Status register layout
   localparam int BIT_POWER_DOWN = 0;
   localparam int BIT_TIMEOUT    = 1;

   // Values after reset
   localparam logic [7:0] CLK_MODE_RST  = 8'h03;
   localparam logic [7:0] CLK_MODE2_RST = 8'h00;

   // Settling and wake-up counts, in oscillator cycles
   localparam logic [10:0] HS_CRYSTAL_SETTLE_TICKS = 11'h400;
   localparam logic [10:0] HS_RC_SETTLE_TICKS      = 11'h010;
   localparam logic [10:0] LS_CRYSTAL_SETTLE_TICKS = 11'h400;
   localparam logic [10:0] LS_RC_SETTLE_TICKS      = 11'h002;
   localparam logic [1:0]  SUB_WAKE_TICKS    = 2'h2;

   // Clock source codes seen by the glitch-free selector
   localparam logic [2:0] SRC_SUB  = 3'h0;
   localparam logic [2:0] SRC_FULL = 3'h7;

   typedef enum logic [2:0] {
      st_run,
      st_wake,
      st_sleep_all_off,
      st_sleep_sub_on,
      st_idle_sub_only,
      st_idle_sys_on
   } power_state_e;

   // Source code from the clock select fields: sub, /64 .. /2, full
   function automatic logic [2:0] src_of(input logic hs_sel, input logic [2:0] div_sel);
      logic [2:0] code;
      code = SRC_SUB;
      if (hs_sel) begin
         code = SRC_FULL;
      end else if (div_sel[2:1] != 2'h0) begin
         code = div_sel - 3'h1;
      end
      return code;
   endfunction

endpackage

// ===== verilog/hs_clk_divider.sv
`timescale 1ns/1ps
module hs_clk_divider #(
   parameter int DIV_BITS = 6
) (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   // High-speed oscillator tick and its enable
   input  wire logic                hs_en,
   input  wire logic                hs_tick,
   // Divide by 2, 4, .. 2**DIV_BITS strobes
   output logic [DIV_BITS-1:0]      div_ticks
);

   logic [DIV_BITS-1:0] cnt;

   // Counter restarts whenever the oscillator is stopped
   always_ff @(posedge mclk) begin
      if (rst || !hs_en) begin
         cnt <= '0;
      end else if (hs_tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   // Stage k fires on the tick that closes a 2**(k+1) period; constant slice per stage
   for (genvar k = 0; k < DIV_BITS; k++) begin : g_tap
      assign div_ticks[k] = hs_en && hs_tick && (&cnt[k:0]);
   end

endmodule

// ===== verilog/clk_glitchless_sel.sv
`timescale 1ns/1ps
module clk_glitchless_sel #(
   parameter int         N_SRC     = 8,
   parameter logic [2:0] RESET_SEL = 3'h7
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Candidate sources
   input  wire logic [N_SRC-1:0] src_ticks,
   input  wire logic [N_SRC-1:0] src_alive,
   // Selection
   input  wire logic [2:0]       req_sel,
   output logic [2:0]            cur_sel,
   // Selected clock strobe
   output logic                  tick_out
);

   logic parked;

   // Old period is finished before the new source is taken, so no short pulse
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_sel <= RESET_SEL;
         parked  <= 1'b0;
      end else if (!parked && (req_sel != cur_sel)
                   && (src_ticks[cur_sel] || !src_alive[cur_sel])) begin
         parked <= 1'b1;
      end else if (parked && src_ticks[req_sel]) begin
         cur_sel <= req_sel;
         parked  <= 1'b0;
      end
   end

   // While parked only the first edge of the new source passes
   assign tick_out = parked ? src_ticks[req_sel] : src_ticks[cur_sel];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_switch_parked: assert property ($changed(cur_sel) |-> $past(parked))
      else $error("source changed without parking");
   chk_parked_quiet: assert property (parked && !src_ticks[req_sel] |-> !tick_out)
      else $error("tick passed while parked");

endmodule

// ===== verilog/power_mode_wakeup_clock_ctrl.sv
// What this block does
// - Fast wake runs sub clock, crystal after settle
// - RC oscillators wake in fixed short counts
// - Fast wake only from sub-on sleep, idle
// - One register bit enables fast wake
// - Codes 000/001 without full select: slow
// - Report sub ready; switch waits for it
// - Return to high speed on other codes
// - Sub clock selected stops high-speed oscillator
// - Halt, sleep, no watchdog/detector: all clocks off
// - All-off sleep clears and holds watchdog
// - Halt, sleep, watchdog/detector on: sub runs
// - Halt, idle, sysclk off: sub only
// - Halt, idle, sysclk on: both run
// - Low-power states freeze memory, registers, ports
// - Entry sets power-down, clears timeout flag
// - Divider codes choose sub or divided clock
// - Full select uses undivided high-speed clock
// - High-speed ready low asleep, settles after
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module power_mode_wakeup_clock_ctrl (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst,
   // Register port
   input  wire logic [1:0]                 reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [7:0]                      reg_rdata,
   // Processor core
   input  wire logic                       halt_req,
   input  wire logic                       wake_req,
   output logic                            core_stall,
   output logic                            sys_tick,
   // Configuration straps and watchdog events
   input  wire logic                       hs_is_rc,
   input  wire logic                       sub_is_crystal,
   input  wire logic                       wdt_enabled,
   input  wire logic                       low_volt_detect_en,
   input  wire logic                       wdt_timeout,
   input  wire logic                       wdt_clr_insn,
   // Oscillators
   input  wire logic                       hs_tick,
   input  wire logic                       ls_tick,
   output logic                            hs_osc_en,
   output logic                            sub_osc_en,
   output logic                            hs_div16_tick,
   output logic                            hs_div64_tick,
   // Side effects of the power states
   output logic                            wdt_clear,
   output logic                            wdt_hold,
   output logic                            retain_hold,
   output power_clk_pkg::power_state_e     power_state
);
   import power_clk_pkg::*;

   power_state_e state;
   power_state_e next_state;
   power_state_e last_lp;
   logic [2:0]   div_sel;
   logic         fast_wake_en;
   logic         idle_select;
   logic         hs_select;
   logic         idle_sysclk_on;
   logic [3:0]   rst_flags;
   logic         hs_ready;
   logic         ls_ready;
   logic         power_down_flag;
   logic         timeout_flag;
   logic         fast_run;
   logic [10:0]  hs_cnt;
   logic [10:0]  ls_cnt;
   logic [10:0]  hs_settle;
   logic [10:0]  ls_settle;
   logic [1:0]   wk_cnt;
   logic [2:0]   want_sel;
   logic [2:0]   target_sel;
   logic [2:0]   req_sel;
   logic [2:0]   cur_sel;
   logic         want_hs;
   logic         target_ready;
   logic         fast_ok;
   logic         sub_done;
   logic         wake_done;
   logic         halt_ok;
   logic         mux_tick;
   logic [5:0]   div_ticks;
   logic [7:0]   src_ticks;
   logic [7:0]   src_alive;
   logic [7:0]   next_rdata;

   // Software-owned control bits
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_sel        <= CLK_MODE_RST[DIV_SEL_MSB:DIV_SEL_LSB];
         fast_wake_en   <= CLK_MODE_RST[BIT_FAST_WAKE_EN];
         idle_select    <= CLK_MODE_RST[BIT_IDLE_SELECT];
         hs_select      <= CLK_MODE_RST[BIT_HS_SELECT];
         idle_sysclk_on <= CLK_MODE2_RST[BIT_IDLE_SYSCLK_ON];
         rst_flags      <= CLK_MODE2_RST[RST_FLAGS_MSB:RST_FLAGS_LSB];
      end else if (reg_wr && reg_addr == ADDR_CLK_MODE) begin
         div_sel      <= reg_wdata[DIV_SEL_MSB:DIV_SEL_LSB];
         fast_wake_en <= reg_wdata[BIT_FAST_WAKE_EN];
         idle_select  <= reg_wdata[BIT_IDLE_SELECT];
         hs_select    <= reg_wdata[BIT_HS_SELECT];
      end else if (reg_wr && reg_addr == ADDR_CLK_MODE2) begin
         idle_sysclk_on <= reg_wdata[BIT_IDLE_SYSCLK_ON];
         rst_flags      <= reg_wdata[RST_FLAGS_MSB:RST_FLAGS_LSB];
      end
   end

   // Read data; unmapped and reserved bits read as zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ADDR_CLK_MODE: begin
            next_rdata[DIV_SEL_MSB:DIV_SEL_LSB] = div_sel;
            next_rdata[BIT_FAST_WAKE_EN]        = fast_wake_en;
            next_rdata[BIT_LS_READY]            = ls_ready;
            next_rdata[BIT_HS_READY]            = hs_ready;
            next_rdata[BIT_IDLE_SELECT]         = idle_select;
            next_rdata[BIT_HS_SELECT]           = hs_select;
         end
         ADDR_CLK_MODE2: begin
            next_rdata[BIT_IDLE_SYSCLK_ON]          = idle_sysclk_on;
            next_rdata[RST_FLAGS_MSB:RST_FLAGS_LSB] = rst_flags;
         end
         ADDR_STATUS: begin
            next_rdata[BIT_POWER_DOWN] = power_down_flag;
            next_rdata[BIT_TIMEOUT]    = timeout_flag;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   // Data valid only in the cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   assign halt_ok = (state == st_run) && halt_req;

   // Power state sequencer; halt is only honoured while running
   always_comb begin
      next_state = state;
      case (state)
         st_run: begin
            if (halt_req && !idle_select) begin
               next_state = (wdt_enabled || low_volt_detect_en) ? st_sleep_sub_on
                                                                : st_sleep_all_off;
            end else if (halt_req) begin
               next_state = idle_sysclk_on ? st_idle_sys_on : st_idle_sub_only;
            end
         end
         st_wake: begin
            if (wake_done) begin
               next_state = st_run;
            end
         end
         st_sleep_all_off, st_sleep_sub_on, st_idle_sub_only, st_idle_sys_on: begin
            if (wake_req) begin
               next_state = st_wake;
            end
         end
         default: next_state = st_wake;
      endcase
   end

   // Power-on starts in wake so the core waits for the oscillator
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= st_wake;
      end else begin
         state <= next_state;
      end
   end

   // Remember which low-power state the wake-up leaves
   always_ff @(posedge mclk) begin
      if (rst) begin
         last_lp <= st_sleep_all_off;
      end else if (halt_ok) begin
         last_lp <= next_state;
      end
   end

   // Power-down and timeout flags; a watchdog event beats any clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         power_down_flag <= 1'b0;
         timeout_flag    <= 1'b0;
      end else begin
         if (halt_ok) begin
            power_down_flag <= 1'b1;
         end else if (wdt_clr_insn) begin
            power_down_flag <= 1'b0;
         end
         if (wdt_timeout) begin
            timeout_flag <= 1'b1;
         end else if (halt_ok || wdt_clr_insn) begin
            timeout_flag <= 1'b0;
         end
      end
   end

   // Oscillator enables follow the state and the chosen source
   assign sub_osc_en = (state != st_sleep_all_off);
   assign hs_osc_en  = (state == st_run || state == st_wake || state == st_idle_sys_on)
                       && (want_hs || fast_run || cur_sel != SRC_SUB);
   assign hs_settle  = hs_is_rc ? HS_RC_SETTLE_TICKS : HS_CRYSTAL_SETTLE_TICKS;
   assign ls_settle  = sub_is_crystal ? LS_CRYSTAL_SETTLE_TICKS : LS_RC_SETTLE_TICKS;

   // High-speed ready: cleared at the halt edge, so already low in the first sleep cycle
   always_ff @(posedge mclk) begin
      if (rst || !hs_osc_en || (halt_ok && next_state != st_idle_sys_on)) begin
         hs_cnt   <= 11'h000;
         hs_ready <= 1'b0;
      end else if (hs_tick && !hs_ready) begin
         hs_cnt <= hs_cnt + 11'h001;
         if (hs_cnt == hs_settle - 11'h001) begin
            hs_ready <= 1'b1;
         end
      end
   end

   // Sub clock ready: only the all-off sleep stops it, cleared on the entry edge
   always_ff @(posedge mclk) begin
      if (rst || !sub_osc_en || (halt_ok && next_state == st_sleep_all_off)) begin
         ls_cnt   <= 11'h000;
         ls_ready <= 1'b0;
      end else if (ls_tick && !ls_ready) begin
         ls_cnt <= ls_cnt + 11'h001;
         if (ls_cnt == ls_settle - 11'h001) begin
            ls_ready <= 1'b1;
         end
      end
   end

   // Short sub clock wake count, one to two sub periods
   always_ff @(posedge mclk) begin
      if (rst || state != st_wake) begin
         wk_cnt <= 2'h0;
      end else if (ls_tick && wk_cnt != SUB_WAKE_TICKS) begin
         wk_cnt <= wk_cnt + 2'h1;
      end
   end

   assign want_sel = src_of(hs_select, div_sel);
   assign want_hs  = (want_sel != SRC_SUB);
   assign sub_done = ls_ready && (wk_cnt == SUB_WAKE_TICKS);
   // Fast wake needs a crystal and a sub clock that kept running
   assign fast_ok  = fast_wake_en && !hs_is_rc
                     && (last_lp == st_sleep_sub_on || last_lp == st_idle_sub_only);

   // Wake delay depends on the oscillator that will carry the core
   always_comb begin
      if (last_lp == st_idle_sys_on) begin
         wake_done = 1'b1;
      end else if (want_hs) begin
         wake_done = fast_ok ? sub_done : hs_ready;
      end else begin
         wake_done = sub_done;
      end
   end

   // Temporary sub clock run until the crystal is ready
   always_ff @(posedge mclk) begin
      if (rst || halt_ok) begin
         fast_run <= 1'b0;
      end else if (state == st_wake && wake_done && want_hs && fast_ok && !hs_ready) begin
         fast_run <= 1'b1;
      end else if (hs_ready) begin
         fast_run <= 1'b0;
      end
   end

   // Move only to a source that is already stable
   assign target_sel   = fast_run ? SRC_SUB : want_sel;
   assign target_ready = (target_sel == SRC_SUB) ? ls_ready : hs_ready;
   assign req_sel      = target_ready ? target_sel : cur_sel;

   // Sources by code: sub, /64, /32, /16, /8, /4, /2, full
   assign src_ticks = {hs_tick, div_ticks[0], div_ticks[1], div_ticks[2],
                       div_ticks[3], div_ticks[4], div_ticks[5], ls_tick && sub_osc_en};
   assign src_alive = {{7{hs_ready}}, ls_ready};

   hs_clk_divider #(
      .DIV_BITS (6)
   ) u_div (
      .mclk      (mclk),
      .rst       (rst),
      .hs_en     (hs_osc_en),
      .hs_tick   (hs_tick),
      .div_ticks (div_ticks)
   );

   clk_glitchless_sel #(
      .N_SRC     (8),
      .RESET_SEL (SRC_FULL)
   ) u_sel (
      .mclk      (mclk),
      .rst       (rst),
      .src_ticks (src_ticks),
      .src_alive (src_alive),
      .req_sel   (req_sel),
      .cur_sel   (cur_sel),
      .tick_out  (mux_tick)
   );

   // Divided taps die with the oscillator, which timers must tolerate
   assign hs_div16_tick = div_ticks[3];
   assign hs_div64_tick = div_ticks[5];

   // Core and peripheral clock; the core is held during wake and halt
   assign sys_tick    = (state == st_run || state == st_idle_sys_on) && mux_tick;
   assign core_stall  = (state != st_run);
   assign wdt_clear   = halt_ok;
   assign wdt_hold    = (state == st_sleep_all_off);
   assign retain_hold = (state != st_run) && (state != st_wake);
   assign power_state = state;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_sleep_all_off: assert property (
      halt_ok && !idle_select && !wdt_enabled && !low_volt_detect_en
      |=> state == st_sleep_all_off && !sub_osc_en && !sys_tick && !hs_osc_en)
      else $error("all-off sleep entry wrong");
   chk_wdt_held: assert property (state == st_sleep_all_off |-> wdt_hold && !ls_ready)
      else $error("watchdog not held in all-off sleep");
   chk_sleep_sub: assert property (
      halt_ok && !idle_select && (wdt_enabled || low_volt_detect_en)
      |-> wdt_clear ##1 state == st_sleep_sub_on && sub_osc_en && !sys_tick)
      else $error("sub-on sleep entry wrong");
   chk_idle_sub: assert property (
      halt_ok && idle_select && !idle_sysclk_on
      |=> state == st_idle_sub_only && sub_osc_en && !hs_osc_en)
      else $error("sub-only idle entry wrong");
   chk_idle_sys: assert property (
      halt_ok && idle_select && idle_sysclk_on |=> state == st_idle_sys_on && core_stall)
      else $error("system-on idle entry wrong");
   chk_flags_entry: assert property (
      halt_ok && !wdt_timeout |=> power_down_flag && !timeout_flag)
      else $error("power-down flags wrong after halt");
   chk_hs_low_asleep: assert property (
      state inside {st_sleep_all_off, st_sleep_sub_on, st_idle_sub_only} |-> !hs_ready)
      else $error("hs ready high while asleep");
   chk_stall_wake: assert property (
      state == st_wake && !wake_done |=> core_stall && state == st_wake)
      else $error("core released before wake delay");
   chk_fast_end: assert property ($fell(fast_run) && !$past(halt_ok) |-> $past(hs_ready))
      else $error("fast wake ended before crystal ready");
   chk_fast_source: assert property ($rose(fast_run) |-> fast_wake_en && !hs_is_rc
      && last_lp inside {st_sleep_sub_on, st_idle_sub_only})
      else $error("fast wake from wrong state");
   chk_sub_wake: assert property (state == st_wake && !want_hs
      && last_lp != st_idle_sys_on && next_state == st_run |-> wk_cnt == SUB_WAKE_TICKS)
      else $error("sub clock wake too early");
   chk_slow_ready: assert property ($changed(cur_sel) && cur_sel == SRC_SUB |-> ls_ready)
      else $error("switched to sub clock before ready");
   chk_hs_stopped: assert property (
      cur_sel == SRC_SUB && !want_hs && !fast_run |-> !hs_osc_en)
      else $error("high-speed oscillator left running");

   cov_fast_wake: cover property (fast_run && hs_ready); // Crystal takes over
   cov_slow_mode: cover property ($changed(cur_sel) && cur_sel == SRC_SUB);
   cov_all_off:   cover property (state == st_sleep_all_off ##1 state == st_wake);
   cov_idle_sys:  cover property (state == st_idle_sys_on && sys_tick);

endmodule

// ===== bench/osc_model.sv
`timescale 1ns/1ps
module osc_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Oscillator enables from the block
   input  wire logic hs_osc_en,
   input  wire logic sub_osc_en,
   // Oscillator ticks
   output logic      hs_tick,
   output logic      ls_tick
);
   logic [3:0] phase;

   // Ticks stand still while an oscillator is off, like a stopped crystal
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase   <= 4'h0;
         hs_tick <= 1'b0;
         ls_tick <= 1'b0;
      end else begin
         phase   <= phase + 4'h1;
         hs_tick <= hs_osc_en & phase[0];             // Every second cycle
         ls_tick <= sub_osc_en & (phase == 4'hf);     // Every sixteenth cycle
      end
   end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
   import power_clk_pkg::*;
   typedef struct {
      logic [7:0]   mode;
      logic [7:0]   m2;
      logic         wdt;
      logic         volt;
      power_state_e st;
      logic         sub;
      logic         quick;
   } row_s;
   // Stimulus
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic halt_req = 1'b0, wake_req = 1'b0, wdt_enabled = 1'b0, low_volt_detect_en = 1'b0;
   logic wdt_timeout = 1'b0, hs_is_rc = 1'b0, sub_is_crystal = 1'b0, wdt_clr_insn = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   // Observed
   logic [7:0] reg_rdata, rv;
   logic core_stall, sys_tick, hs_tick, ls_tick, hs_osc_en, sub_osc_en;
   logic hs_div16_tick, hs_div64_tick, wdt_clear, wdt_hold, retain_hold, div_seen;
   power_state_e power_state;
   int fail_count = 0, checks_done = 0, n, cnt;
   row_s rows [7];

   always #2.5 mclk = ~mclk;

   power_mode_wakeup_clock_ctrl dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .halt_req, .wake_req, .core_stall, .sys_tick, .hs_is_rc, .sub_is_crystal,
      .wdt_enabled, .low_volt_detect_en, .wdt_timeout, .wdt_clr_insn, .hs_tick, .ls_tick,
      .hs_osc_en, .sub_osc_en, .hs_div16_tick, .hs_div64_tick, .wdt_clear, .wdt_hold,
      .retain_hold, .power_state);
   osc_model osc (.mclk, .rst, .hs_osc_en, .sub_osc_en, .hs_tick, .ls_tick);

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Register write; a spare edge keeps strobes from being reassigned in one step
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask

   // Bounded wait for the core release
   task automatic wait_run(output int k);
      k = 0;
      while (core_stall !== 1'b0) begin
         @(posedge mclk);
         #1 k++;
         if (k > 3000) begin
            fail_count++;
            $display("CHECK FAILED %0t wake timeout", $time);
            close_out();
         end
      end
   endtask

   // System ticks over a window that spans whole periods of every divider
   task automatic count_ticks(output int c);
      c = 0;
      div_seen = 1'b0;
      repeat (256) begin
         @(posedge mclk);
         #1 c += (sys_tick === 1'b1);
         div_seen |= hs_div16_tick | hs_div64_tick;
      end
   endtask

   // One halt, a few quiet cycles, one wake, then the bounded wait for release
   task automatic halt_wake(output int k);
      halt_req <= 1'b1;
      @(posedge mclk);
      halt_req <= 1'b0;
      repeat (4) @(posedge mclk);
      wake_req <= 1'b1;
      @(posedge mclk);
      wake_req <= 1'b0;
      wait_run(k);
   endtask

   initial begin
      rows = '{'{8'h01, 8'h00, 1'b0, 1'b0, st_sleep_all_off, 1'b0, 1'b0},
               '{8'h01, 8'h00, 1'b1, 1'b0, st_sleep_sub_on, 1'b1, 1'b0},
               '{8'h01, 8'h00, 1'b0, 1'b1, st_sleep_sub_on, 1'b1, 1'b0},
               '{8'h03, 8'h00, 1'b0, 1'b0, st_idle_sub_only, 1'b1, 1'b0},
               '{8'h03, 8'h80, 1'b0, 1'b0, st_idle_sys_on, 1'b1, 1'b1},
               '{8'h11, 8'h00, 1'b0, 1'b0, st_sleep_all_off, 1'b0, 1'b0},
               '{8'h11, 8'h00, 1'b1, 1'b0, st_sleep_sub_on, 1'b1, 1'b1}};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 `CHK(core_stall, 1'b1, "stall after reset")
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h03, "mode reset value")
      rd(ADDR_CLK_MODE2, rv);
      `CHK(rv, 8'h00, "mode2 reset value")
      rd(2'h3, rv);
      `CHK(rv, 8'h00, "unmapped read")
      wait_run(n);
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h0f, "both ready after power-on")
      // One halt and wake per row
      foreach (rows[i]) begin
         wdt_enabled        <= rows[i].wdt;
         low_volt_detect_en <= rows[i].volt;
         wr(ADDR_CLK_MODE, rows[i].mode);
         wr(ADDR_CLK_MODE2, rows[i].m2);
         wdt_timeout <= 1'b1;
         @(posedge mclk);
         wdt_timeout <= 1'b0;
         halt_req    <= 1'b1;
         #1 `CHK(wdt_clear, 1'b1, "halt clears watchdog")
         @(posedge mclk);
         halt_req <= 1'b0;
         #1 `CHK(power_state, rows[i].st, "low-power state")
         `CHK(sub_osc_en, rows[i].sub, "sub clock enable")
         `CHK(wdt_hold, rows[i].st == st_sleep_all_off, "watchdog hold")
         `CHK(retain_hold, 1'b1, "retention")
         rd(ADDR_STATUS, rv);
         `CHK(rv, 8'h01, "power-down set, timeout cleared")
         rd(ADDR_CLK_MODE2, rv);
         `CHK(rv, rows[i].m2, "register kept")
         wake_req <= 1'b1;
         @(posedge mclk);
         wake_req <= 1'b0;
         wait_run(n);
         `CHK(n < 40, rows[i].quick, "wake time class")
      end
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h19, "fast wake runs before crystal ready")
      repeat (2100) @(posedge mclk);
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h1d, "crystal ready after settling")
      // Slow mode stops the high-speed side
      wr(ADDR_CLK_MODE, 8'h00);
      repeat (300) @(posedge mclk);
      #1 `CHK(hs_osc_en, 1'b0, "high-speed stopped")
      count_ticks(cnt);
      `CHK(cnt, 16, "sub clock rate")
      `CHK(div_seen, 1'b0, "divided clocks stopped")
      for (int c = 2; c < 8; c++) begin
         wr(ADDR_CLK_MODE, {c[2:0], 5'h00});
         repeat (c == 2 ? 2300 : 300) @(posedge mclk);
         count_ticks(cnt);
         // Model ticks every second cycle, so the slowest tap still shows twice
         `CHK(cnt, 2 << (c - 2), "divided rate")
      end
      wr(ADDR_CLK_MODE, 8'h01);
      repeat (300) @(posedge mclk);
      count_ticks(cnt);
      `CHK(cnt, 128, "undivided rate")
      `CHK(div_seen, 1'b1, "divided clocks run")
      // Awkward cases: RC wake, slow-mode wake, flag race, mid-run reset
      hs_is_rc <= 1'b1;
      wr(ADDR_CLK_MODE, 8'h11);
      halt_wake(n);
      `CHK(n >= 32 && n <= 35, 1'b1, "rc wake in sixteen ticks")
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h1d, "rc wake ignores fast wake")
      wr(ADDR_CLK_MODE, 8'h02);
      repeat (40) @(posedge mclk);
      halt_wake(n);
      `CHK(n >= 18 && n <= 33, 1'b1, "sub clock wake in two ticks")
      `CHK(retain_hold, 1'b0, "no retention while running")
      wdt_timeout  <= 1'b1;
      wdt_clr_insn <= 1'b1;
      @(posedge mclk);
      wdt_timeout  <= 1'b0;
      wdt_clr_insn <= 1'b0;
      rd(ADDR_STATUS, rv);
      `CHK(rv, 8'h02, "timeout set beats clear")
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 `CHK(power_state, st_wake, "wake state after reset")
      rd(ADDR_CLK_MODE, rv);
      `CHK(rv, 8'h03, "mode cleared by reset")
      wait_run(n);
      `CHK(n < 40, 1'b1, "rc power-on wait")
      close_out();
   end
endmodule
